// ### rtl/timer16_waveform_output_control.v
// 16-bit timer waveform generation and compare output control, AXI4-Lite
`timescale 1ns/1ns
`include "tc_wave_map.vh"

module timer16_waveform_output_control (
    input  wire        aclk,             // 250 MHz clock
    input  wire        aresetn,          // Synchronous reset, active low
    input  wire [5:0]  s_axi_awaddr,     // Write address
    input  wire        s_axi_awvalid,    // Write address valid
    output reg         s_axi_awready,    // Write address ready
    input  wire [31:0] s_axi_wdata,      // Write data
    input  wire [3:0]  s_axi_wstrb,      // Write byte lanes
    input  wire        s_axi_wvalid,     // Write data valid
    output reg         s_axi_wready,     // Write data ready
    output reg  [1:0]  s_axi_bresp,      // Write response
    output reg         s_axi_bvalid,     // Write response valid
    input  wire        s_axi_bready,     // Write response ready
    input  wire [5:0]  s_axi_araddr,     // Read address
    input  wire        s_axi_arvalid,    // Read address valid
    output reg         s_axi_arready,    // Read address ready
    output reg  [31:0] s_axi_rdata,      // Read data
    output reg  [1:0]  s_axi_rresp,      // Read response
    output reg         s_axi_rvalid,     // Read data valid
    input  wire        s_axi_rready,     // Read data ready
    output reg         chan_a_wave_out,  // Channel A waveform level
    output reg         chan_b_wave_out,  // Channel B waveform level
    output reg  [3:0]  chan_a_pin_drive, // Channel A owns these pins
    output reg  [3:0]  chan_b_pin_drive, // Channel B owns these pins
    output reg         irq               // Level interrupt
);

    reg  [1:0]  mode_a_q;
    reg  [1:0]  mode_b_q;
    reg  [1:0]  wgm_lo_q;
    reg  [1:0]  wgm_hi_q;
    reg  [2:0]  csel_q;
    reg  [7:0]  pin_en_q;
    reg  [15:0] buf_a_q;
    reg  [15:0] buf_b_q;
    reg  [15:0] capt_q;
    reg  [31:0] ocr_act_q;
    reg  [2:0]  st_q;
    reg  [2:0]  mask_q;
    reg  [15:0] cnt_q;
    reg         up_q;
    reg  [9:0]  ps_q;
    reg         aw_hold_q;
    reg  [5:0]  aw_addr_q;
    reg         w_hold_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire [3:0]  waveform_mode_number = {wgm_hi_q, wgm_lo_q};
    wire [1:0]  wave_class;
    wire [1:0]  top_src;
    wire [15:0] fixed_top;
    wire [1:0]  upd_point;
    wire [1:0]  ovf_point;

    wave_mode_decode u_decode (
        .waveform_mode_number (waveform_mode_number),
        .wave_class           (wave_class),
        .top_src              (top_src),
        .fixed_top            (fixed_top),
        .upd_point            (upd_point),
        .ovf_point            (ovf_point)
    );

    // Output level after one clock tick for a channel
    function wave_next;
        input [1:0] cls;
        input [1:0] com;
        input       hit;
        input       top_ev;
        input       up;
        input       alt_tog;
        input       cur;
        begin
            wave_next = cur;
            if (com == `COM_TOGGLE)
            begin
                if (hit && (cls == `CLS_NONPWM || alt_tog))
                    wave_next = ~cur;
            end
            else if (com != `COM_OFF)
            begin
                case (cls)
                    `CLS_NONPWM: if (hit) wave_next = (com == `COM_SET);
                    `CLS_FAST:
                    begin
                        if (top_ev)
                            wave_next = (com == `COM_CLEAR);
                        else if (hit)
                            wave_next = (com == `COM_SET);
                    end
                    `CLS_DUAL:   if (hit) wave_next = (com == `COM_SET) ? up : ~up;
                    default:     wave_next = cur;
                endcase
            end
        end
    endfunction

    // Prescaler; external clock codes have no pin here and leave the counter stopped
    reg  [9:0] div_lim;
    reg        run;
    always @*
    begin
        run = 1'b1;
        case (csel_q)
            `CS_DIV1:    div_lim = `DIV_1;
            `CS_DIV8:    div_lim = `DIV_8;
            `CS_DIV64:   div_lim = `DIV_64;
            `CS_DIV256:  div_lim = `DIV_256;
            `CS_DIV1024: div_lim = `DIV_1024;
            default:
            begin
                div_lim = `DIV_1;
                run     = 1'b0;
            end
        endcase
    end
    wire tick = run && (ps_q == div_lim);

    reg [15:0] top;
    always @*
    begin
        case (top_src)
            `TS_CMPA: top = ocr_act_q[15:0];
            `TS_CAPT: top = capt_q;
            default:  top = fixed_top;
        endcase
    end

    wire at_top = (cnt_q == top);
    wire at_bot = (cnt_q == `BOTTOM);
    // Turning points count as the slope they begin, so extreme compares hold steady
    wire eff_up = at_top ? 1'b0 : (at_bot ? 1'b1 : up_q);
    wire top_ev = tick && at_top;

    reg ovf_ev;
    reg upd_ev;
    always @*
    begin
        case (ovf_point)
            `PT_TOP: ovf_ev = top_ev;
            `PT_BOT: ovf_ev = tick && at_bot;
            default: ovf_ev = tick && (cnt_q == `TOP_MAX);
        endcase
        case (upd_point)
            `PT_TOP: upd_ev = top_ev;
            `PT_BOT: upd_ev = tick && at_bot;
            default: upd_ev = 1'b1;
        endcase
    end

    wire [3:0]  com_all = {mode_b_q, mode_a_q};
    wire [31:0] buf_all = {buf_b_q, buf_a_q};
    wire [1:0]  wave_cur = {chan_b_wave_out, chan_a_wave_out};
    wire [1:0]  wave_d;
    wire [7:0]  drive_d;
    wire [1:0]  match_v;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_chan
            wire [1:0]  com = com_all[2*ch+1:2*ch];
            wire [15:0] ocr = ocr_act_q[16*ch+15:16*ch];
            wire        alt = wgm_hi_q[1] && (ch == 0);
            wire        pwm = (wave_class != `CLS_NONPWM);
            wire        hit = tick && (cnt_q == ocr);
            // Match on top is dropped in fast PWM when the top action owns it
            wire        hit_eff = hit && !(wave_class == `CLS_FAST && com[1] && ocr == top);
            wire        conn = (com != `COM_OFF) &&
                               !(pwm && com == `COM_TOGGLE && !alt);
            assign match_v[ch] = hit;
            assign wave_d[ch] = wave_next(wave_class, com, hit_eff, top_ev, eff_up, alt, wave_cur[ch]);
            assign drive_d[4*ch+3:4*ch] = pin_en_q[4*ch+3:4*ch] & {4{conn}};
        end
    endgenerate

    // Counter and compare buffers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q     <= `RST_WORD;
            up_q      <= 1'b1;
            ps_q      <= `DIV_1;
            ocr_act_q <= {`RST_WORD, `RST_WORD};
        end
        else
        begin
            ps_q <= (tick || !run) ? `DIV_1 : ps_q + 10'h001;
            if (upd_ev)
                ocr_act_q <= buf_all;
            if (tick)
            begin
                if (wave_class == `CLS_DUAL)
                begin
                    if (up_q && at_top)
                    begin
                        up_q  <= 1'b0;
                        cnt_q <= at_bot ? cnt_q : cnt_q - 16'h0001;
                    end
                    else if (!up_q && at_bot)
                    begin
                        up_q  <= 1'b1;
                        cnt_q <= cnt_q + 16'h0001;
                    end
                    else
                        cnt_q <= up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
                else
                begin
                    up_q  <= 1'b1;
                    cnt_q <= at_top ? `BOTTOM : cnt_q + 16'h0001;
                end
            end
        end
    end

    // Outputs and interrupt status; a new event beats a same-cycle clear
    wire        wr_go  = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire        st_wr  = wr_go && (aw_addr_q == `OFS_STATUS) && w_strb_q[0];
    wire [2:0]  st_set = {match_v[1], match_v[0], ovf_ev};
    wire [2:0]  st_d   = (st_q & ~(st_wr ? w_data_q[2:0] : 3'h0)) | st_set;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chan_a_wave_out  <= 1'b0;
            chan_b_wave_out  <= 1'b0;
            chan_a_pin_drive <= 4'h0;
            chan_b_pin_drive <= 4'h0;
            st_q             <= `RST_ST;
            irq              <= 1'b0;
        end
        else
        begin
            chan_a_wave_out  <= wave_d[0];
            chan_b_wave_out  <= wave_d[1];
            chan_a_pin_drive <= drive_d[`PE_A];
            chan_b_pin_drive <= drive_d[`PE_B];
            st_q             <= st_d;
            irq              <= |(st_d & mask_q);
        end
    end

    // AXI4-Lite write side
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_hold_q     <= 1'b0;
            aw_addr_q     <= 6'h00;
            w_hold_q      <= 1'b0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            mode_a_q      <= 2'h0;
            mode_b_q      <= 2'h0;
            wgm_lo_q      <= 2'h0;
            wgm_hi_q      <= 2'h0;
            csel_q        <= 3'h0;
            pin_en_q      <= `RST_BYTE;
            buf_a_q       <= `RST_WORD;
            buf_b_q       <= `RST_WORD;
            capt_q        <= `RST_WORD;
            mask_q        <= `RST_ST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_q)
                    `OFS_CTRL_A: if (w_strb_q[0])
                    begin
                        mode_a_q <= w_data_q[`CA_MODE_A];
                        mode_b_q <= w_data_q[`CA_MODE_B];
                        wgm_lo_q <= w_data_q[`CA_WGM_LO];
                    end
                    `OFS_CTRL_B: if (w_strb_q[0])
                    begin
                        wgm_hi_q <= w_data_q[`CB_WGM_HI];
                        csel_q   <= w_data_q[`CB_CSEL];
                    end
                    `OFS_PIN_EN: if (w_strb_q[0]) pin_en_q <= w_data_q[7:0];
                    `OFS_CMP_A:
                    begin
                        if (w_strb_q[0]) buf_a_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) buf_a_q[15:8] <= w_data_q[15:8];
                    end
                    `OFS_CMP_B:
                    begin
                        if (w_strb_q[0]) buf_b_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) buf_b_q[15:8] <= w_data_q[15:8];
                    end
                    `OFS_CAPT:
                    begin
                        if (w_strb_q[0]) capt_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) capt_q[15:8] <= w_data_q[15:8];
                    end
                    `OFS_MASK:   if (w_strb_q[0]) mask_q <= w_data_q[2:0];
                    `OFS_STATUS, `OFS_COUNT: s_axi_bresp <= `RESP_OKAY;
                    default:     s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            case (s_axi_araddr)
                `OFS_CTRL_A: s_axi_rdata[7:0] <= {mode_a_q, mode_b_q, 2'b00, wgm_lo_q};
                `OFS_CTRL_B: s_axi_rdata[4:0] <= {wgm_hi_q, csel_q};
                `OFS_PIN_EN: s_axi_rdata[7:0] <= pin_en_q;
                `OFS_CMP_A:  s_axi_rdata[15:0] <= buf_a_q;
                `OFS_CMP_B:  s_axi_rdata[15:0] <= buf_b_q;
                `OFS_CAPT:   s_axi_rdata[15:0] <= capt_q;
                `OFS_STATUS: s_axi_rdata[2:0] <= st_q;
                `OFS_MASK:   s_axi_rdata[2:0] <= mask_q;
                `OFS_COUNT:  s_axi_rdata[16:0] <= {up_q, cnt_q};
                default:     s_axi_rresp <= `RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // timer16_waveform_output_control

// ### rtl/tc_wave_map.vh
// Register map, field positions and mode encodings of the waveform timer
`ifndef TC_WAVE_MAP_VH
`define TC_WAVE_MAP_VH

`define OFS_CTRL_A   6'h00
`define OFS_CTRL_B   6'h04
`define OFS_PIN_EN   6'h08
`define OFS_CMP_A    6'h0C
`define OFS_CMP_B    6'h10
`define OFS_CAPT     6'h14
`define OFS_STATUS   6'h18
`define OFS_MASK     6'h1C
`define OFS_COUNT    6'h20

`define CA_MODE_A    7:6
`define CA_MODE_B    5:4
`define CA_RSVD      3:2
`define CA_WGM_LO    1:0
`define CB_WGM_HI    4:3
`define CB_CSEL      2:0
`define PE_B         7:4
`define PE_A         3:0

`define ST_OVF       0
`define ST_MATCH_A   1
`define ST_MATCH_B   2

`define RST_BYTE     8'h00
`define RST_WORD     16'h0000
`define RST_ST       3'h0

`define TOP_MAX      16'hFFFF
`define TOP_8B       16'h00FF
`define TOP_9B       16'h01FF
`define TOP_10B      16'h03FF
`define BOTTOM       16'h0000

`define CLS_NONPWM   2'h0
`define CLS_FAST     2'h1
`define CLS_DUAL     2'h2

`define PT_IMM       2'h0
`define PT_TOP       2'h1
`define PT_BOT       2'h2
`define PT_MAX       2'h3

`define TS_FIXED     2'h0
`define TS_CMPA      2'h1
`define TS_CAPT      2'h2

`define COM_OFF      2'h0
`define COM_TOGGLE   2'h1
`define COM_CLEAR    2'h2
`define COM_SET      2'h3

`define CS_DIV1      3'h1
`define CS_DIV8      3'h2
`define CS_DIV64     3'h3
`define CS_DIV256    3'h4
`define CS_DIV1024   3'h5
`define DIV_1        10'h000
`define DIV_8        10'h007
`define DIV_64       10'h03F
`define DIV_256      10'h0FF
`define DIV_1024     10'h3FF

`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ### rtl/wave_mode_decode.v
// Decoder from the four-bit waveform mode number to counter behaviour
`timescale 1ns/1ns
`include "tc_wave_map.vh"

module wave_mode_decode (
    input  wire [3:0]  waveform_mode_number, // Combined mode number
    output reg  [1:0]  wave_class,           // Non-PWM, fast or dual-slope
    output reg  [1:0]  top_src,              // Fixed, compare A or capture
    output reg  [15:0] fixed_top,            // Top when source is fixed
    output reg  [1:0]  upd_point,            // Compare buffer load point
    output reg  [1:0]  ovf_point             // Overflow flag point
);

    always @*
    begin
        wave_class = `CLS_NONPWM;
        top_src    = `TS_FIXED;
        fixed_top  = `TOP_MAX;
        upd_point  = `PT_IMM;
        ovf_point  = `PT_MAX;
        case (waveform_mode_number)
            4'h1, 4'h2, 4'h3:
            begin
                wave_class = `CLS_DUAL;
                upd_point  = `PT_TOP;
                ovf_point  = `PT_BOT;
                fixed_top  = (waveform_mode_number == 4'h1) ? `TOP_8B :
                             (waveform_mode_number == 4'h2) ? `TOP_9B : `TOP_10B;
            end
            4'h4:    top_src = `TS_CMPA;
            4'h5, 4'h6, 4'h7:
            begin
                wave_class = `CLS_FAST;
                upd_point  = `PT_TOP;
                ovf_point  = `PT_TOP;
                fixed_top  = (waveform_mode_number == 4'h5) ? `TOP_8B :
                             (waveform_mode_number == 4'h6) ? `TOP_9B : `TOP_10B;
            end
            4'h8, 4'h9:
            begin
                wave_class = `CLS_DUAL;
                top_src    = waveform_mode_number[0] ? `TS_CMPA : `TS_CAPT;
                upd_point  = `PT_BOT;
                ovf_point  = `PT_BOT;
            end
            4'hA, 4'hB:
            begin
                wave_class = `CLS_DUAL;
                top_src    = waveform_mode_number[0] ? `TS_CMPA : `TS_CAPT;
                upd_point  = `PT_TOP;
                ovf_point  = `PT_BOT;
            end
            4'hC:    top_src = `TS_CAPT;
            4'hE, 4'hF:
            begin
                wave_class = `CLS_FAST;
                top_src    = waveform_mode_number[0] ? `TS_CMPA : `TS_CAPT;
                upd_point  = `PT_TOP;
                ovf_point  = `PT_TOP;
            end
            // Reserved 13 runs as normal so the counter stays defined
            default: wave_class = `CLS_NONPWM;
        endcase
    end

endmodule // wave_mode_decode

// ### bench/wave_ctl_properties.sv
// Bus handshake and output timing checks for the waveform timer
`timescale 1ns/1ns
`include "tc_wave_map.vh"

module wave_ctl_checker (
    input logic        aclk,             // Clock
    input logic        aresetn,          // Reset, active low
    input logic        s_axi_awvalid,    // Write address valid
    input logic        s_axi_awready,    // Write address ready
    input logic        s_axi_wvalid,     // Write data valid
    input logic        s_axi_wready,     // Write data ready
    input logic        s_axi_bvalid,     // Response valid
    input logic        s_axi_bready,     // Response ready
    input logic [1:0]  s_axi_bresp,      // Write response
    input logic        s_axi_arvalid,    // Read address valid
    input logic        s_axi_arready,    // Read address ready
    input logic        s_axi_rvalid,     // Read valid
    input logic        s_axi_rready,     // Read ready
    input logic [31:0] s_axi_rdata,      // Read data
    input logic [1:0]  s_axi_rresp,      // Read response
    input logic        chan_a_wave_out,  // Channel A level
    input logic [3:0]  chan_a_pin_drive, // Channel A pins
    input logic [3:0]  chan_b_pin_drive, // Channel B pins
    input logic        irq               // Interrupt
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    chk_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken during response");
    chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    chk_pin_cause: assert property ($changed(chan_a_pin_drive) || $changed(chan_b_pin_drive)
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("pin ownership changed without a write");
    chk_reset_out: assert property ($rose(aresetn) |-> !irq && !chan_a_wave_out && chan_a_pin_drive == 4'h0)
        else $error("outputs not cleared by reset");

    cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
    cover property ($rose(irq));
    cover property (chan_a_pin_drive != 4'h0 && $changed(chan_a_wave_out));
endmodule // wave_ctl_checker

bind timer16_waveform_output_control wave_ctl_checker i_chk (.*);

// ### bench/pin_load.sv
// External load on the channel A pins with port fallback
`timescale 1ns/1ns

module pin_load (
    input  logic       wave,     // Compare output level
    input  logic [3:0] drive,    // Compare output owns pin
    input  logic [3:0] dir_out,  // Port direction, 1 output
    input  logic [3:0] port_val, // Ordinary port level
    output logic [3:0] pin       // Level at the load
);
    // Undriven pins float high through the load's pull-up
    assign pin = (dir_out & drive & {4{wave}}) | (dir_out & ~drive & port_val) | ~dir_out;
endmodule // pin_load

// ### bench/tb.sv
// Self-checking bench for the waveform timer
`timescale 1ns/1ns
`include "tc_wave_map.vh"

module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [5:0]  awaddr = 6'h00;
    logic [5:0]  araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b1;
    logic        arvalid = 1'b0;
    logic        rready = 1'b1;
    logic [3:0]  dir_out = 4'hF;
    logic [3:0]  port_val = 4'hA;
    logic        awready, wready, bvalid, arready, rvalid, wa, wb, irq, p, done;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  pda, pdb, pin;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    integer      errors = 0;
    integer      checks_done = 0;
    integer      seed = 32'hd2e6;
    integer      i, c, n;
    integer      md[0:13] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
    integer      per[0:13] = '{510, 1022, 2046, 96, 256, 512, 1024, 94, 94, 94, 94, 96, 48, 48};
    logic [3:0]  m;

    always #2 aclk = ~aclk;

    timer16_waveform_output_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_a_pin_drive(pda), .chan_b_pin_drive(pdb), .irq(irq));

    pin_load i_load (.wave(wa), .drive(pda), .dir_out(dir_out), .port_val(port_val), .pin(pin));

    task conclude;
        begin
            $display("Counts: %0d checks, %0d errors", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task hang;
        begin
            errors = errors + 1;
            $display("CHECK FAILED wait expected answer seen none");
            conclude;
        end
    endtask

    task check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task rst;
        begin
            aresetn <= 1'b0;
            repeat (5) @(posedge aclk);
            aresetn <= 1'b1;
            @(posedge aclk);
        end
    endtask

    // Caller enters just after a rising edge; bready and rready stay high
    task wr(input [5:0] a, input [31:0] d, input [1:0] er);
        begin
            bq.push_back(er);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            done = 1'b0;
            for (n = 0; n < 50 && !done; n = n + 1)
            begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                done = bvalid;
            end
            if (!done) hang;
        end
    endtask

    task rd(input [5:0] a, input [31:0] e, input [1:0] er);
        begin
            rq.push_back({er, e});
            araddr <= a;
            arvalid <= 1'b1;
            done = 1'b0;
            for (n = 0; n < 50 && !done; n = n + 1)
            begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
                done = rvalid;
            end
            if (!done) hang;
        end
    endtask

    task cfg(input [3:0] mo, input [1:0] ca, input [1:0] cb, input [2:0] cs);
        begin
            wr(`OFS_CTRL_A, {24'h0, ca, cb, 2'b00, mo[1:0]}, `RESP_OKAY);
            wr(`OFS_CTRL_B, {27'h0, mo[3:2], cs}, `RESP_OKAY);
            repeat (2) @(posedge aclk);
        end
    endtask

    // Cycles until channel B next rises
    task rise(output integer cnt);
        begin
            cnt = 0;
            p = 1'b1;
            while (cnt < 5000 && !(wb && !p))
            begin
                p = wb;
                @(posedge aclk);
                cnt = cnt + 1;
            end
            if (cnt == 5000) hang;
        end
    endtask

    always @(posedge aclk)
    begin
        if (rready && rvalid)
            check("read", {rresp, rdata}, rq.pop_front());
        if (bready && bvalid)
            check("bresp", bresp, bq.pop_front());
    end

    initial
    begin
        rst;
        rd(`OFS_CTRL_A, 32'h0, `RESP_OKAY);
        rd(`OFS_CTRL_B, 32'h0, `RESP_OKAY);
        rd(`OFS_PIN_EN, 32'h0, `RESP_OKAY);
        for (i = 0; i < 4; i = i + 1)
        begin
            c = $random(seed);
            port_val <= c[11:8];
            wr(`OFS_CTRL_A, c, `RESP_OKAY);
            rd(`OFS_CTRL_A, c & 32'hF3, `RESP_OKAY);
        end
        wr(6'h24, 32'hFF, `RESP_SLVERR);
        rd(6'h24, 32'h0, `RESP_SLVERR);
        $display("registers done");
        rst;
        wr(`OFS_CMP_A, 32'h3, `RESP_OKAY);
        wr(`OFS_PIN_EN, 32'h5, `RESP_OKAY);
        wr(`OFS_MASK, 32'h2, `RESP_OKAY);
        cfg(4'd4, 2'b01, 2'b11, 3'd1);
        check("pins a", pda, 4'h5);
        check("pins b", pdb, 4'h0);
        c = 0;
        p = wa;
        repeat (40)
        begin
            @(posedge aclk);
            c = c + (wa !== p);
            p = wa;
        end
        check("toggles", c, 10);
        check("pin level", pin, {port_val[3], wa, port_val[1], wa});
        check("irq", irq, 1'b1);
        cfg(4'd4, 2'b10, 2'b11, 3'd1);
        repeat (8) @(posedge aclk);
        check("clear", wa, 1'b0);
        check("set", wb, 1'b1);
        wr(`OFS_MASK, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("masked", irq, 1'b0);
        rd(`OFS_STATUS, 32'h6, `RESP_OKAY);
        cfg(4'd4, 2'b11, 2'b00, 3'd0);
        wr(`OFS_STATUS, 32'h7, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        wr(`OFS_MASK, 32'h2, `RESP_OKAY);
        cfg(4'd4, 2'b11, 2'b00, 3'd1);
        repeat (8) @(posedge aclk);
        check("set a", wa, 1'b1);
        check("irq again", irq, 1'b1);
        wr(`OFS_PIN_EN, 32'h55, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("b off", pdb, 4'h0);
        cfg(4'd5, 2'b01, 2'b01, 3'd1);
        check("pwm01 low", pda, 4'h0);
        cfg(4'd15, 2'b01, 2'b01, 3'd1);
        check("pwm01 a", pda, 4'h5);
        check("pwm01 b", pdb, 4'h0);
        $display("outputs done");
        rst;
        wr(`OFS_CMP_A, 32'hFF, `RESP_OKAY);
        for (i = 2; i < 4; i = i + 1)
        begin
            cfg(4'd5, i[1:0], 2'b00, 3'd1);
            repeat (300) @(posedge aclk);
            c = 0;
            repeat (256)
            begin
                @(posedge aclk);
                c = c + (wa !== (i == 2));
            end
            check("top compare", c, 0);
        end
        $display("top compare done");
        for (i = 0; i < 14; i = i + 1)
        begin
            m = md[i];
            rst;
            wr(`OFS_CAPT, 32'h2F, `RESP_OKAY);
            wr(`OFS_CMP_A, 32'h2F, `RESP_OKAY);
            wr(`OFS_CMP_B, 32'h10, `RESP_OKAY);
            cfg(m, 2'b00, (m == 4 || m == 12) ? 2'b01 : 2'b10, 3'd1);
            repeat (3) rise(c);
            check("period", c, per[i]);
            rd(`OFS_STATUS, (m == 4 || m == 12) ? 32'h6 : 32'h7, `RESP_OKAY);
        end
        $display("modes done");
        conclude;
    end
endmodule // tb
